// file: core/flash_pe_pkg.sv
package flash_pe_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int FLASH_BYTES = 1024;
  localparam int FLASH_IDX_W = 10;
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_OFF_W = 9;
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] SHORT_ADDR_MAX = 16'h00FF;
  localparam int CLK_MHZ = 25;
  localparam int WRITE_TIME_NS = 400;
  localparam int ERASE_TIME_NS = 20480;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMER_W = 10;
  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_FIRST_SEEN,
    KEY_ARMED,
    KEY_LOCKOUT
  } key_state_t;
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_PROGRAM,
    OP_ERASE
  } op_state_t;
endpackage

// file: core/flash_pe_if.sv
`timescale 1ns/100ps
interface flash_pe_if;
  import flash_pe_pkg::*;
  logic key_wr;
  logic [7:0] key_data;
  logic ctl_wr;
  logic write_enable_in;
  logic erase_enable_in;
  logic timing_enable_in;
  logic ext_wr;
  logic ext_short;
  logic [ADDR_W-1:0] ext_addr;
  logic [DATA_W-1:0] ext_wdata;
  logic ext_rd;
  logic code_rd;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] code_rdata;
  logic [DATA_W-1:0] ram_rdata;
  logic stall;
  logic locked_out;
  logic armed;
  logic program_store_write_enable;
  logic program_store_erase_enable;
  modport device (input key_wr, key_data, ctl_wr, write_enable_in, erase_enable_in, timing_enable_in,
    ext_wr, ext_short, ext_addr, ext_wdata, ext_rd, code_rd, rd_addr,
    output code_rdata, ram_rdata, stall, locked_out, armed, program_store_write_enable,
    program_store_erase_enable);
  modport core (output key_wr, key_data, ctl_wr, write_enable_in, erase_enable_in, timing_enable_in,
    ext_wr, ext_short, ext_addr, ext_wdata, ext_rd, code_rd, rd_addr,
    input code_rdata, ram_rdata, stall, locked_out, armed, program_store_write_enable,
    program_store_erase_enable);
endinterface

// file: core/flash_program_erase_control.sv
// Behaviour
// - Programming only clears bits, erase sets
// - Operations internally timed, core stalled
// - Software sets write timing enable first
// - Short-address flash writes cannot reach above 0x00FF; data RAM writes can
// - Keys 0xA5 then 0xF1 before operation
// - Wrong or misordered key locks until reset
// - Write before unlock locks until reset
// - Relock after each write or erase
// - Write enable steers writes to flash
// - 512-byte pages, erase fills 0xFF
// - Erase on any write within page
// - Byte program with write enable only
// - Unlock again for every byte
// - Software clears write enable afterwards
// - Byte-at-a-time programming accepted
// - External reads always hit data RAM
// - Write needs write enable; erase needs both
`timescale 1ns/100ps
module flash_program_erase_control
  import flash_pe_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  flash_pe_if.device bus
);
  key_state_t key_q;
  key_state_t key_d;
  logic armed_q;
  logic locked_out_q;
  op_state_t op_q;
  logic [TIMER_W-1:0] timer_q;
  logic [FLASH_IDX_W-1:0] op_addr_q;
  logic [FLASH_IDX_W-1:0] erase_idx_q;
  logic [DATA_W-1:0] op_data_q;
  logic we_q;
  logic ee_q;
  logic [DATA_W-1:0] flash_q [FLASH_BYTES];
  logic [DATA_W-1:0] ram_q [FLASH_BYTES];
  logic [DATA_W-1:0] code_rdata_q;
  logic [DATA_W-1:0] ram_rdata_q;
  logic stall_q;
  logic flash_wr;
  logic in_range;
  logic start_op;

  assign flash_wr = bus.ext_wr && we_q && !stall_q;
  assign in_range = !(bus.ext_short && (bus.ext_addr > SHORT_ADDR_MAX));
  assign start_op = flash_wr && in_range && (key_q == KEY_ARMED) && bus.timing_enable_in;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      we_q <= 1'b0;
      ee_q <= 1'b0;
    end else if (bus.ctl_wr) begin
      we_q <= bus.write_enable_in;
      ee_q <= bus.erase_enable_in;
    end
  end

  always_comb begin
    key_d = key_q;
    case (key_q)
      KEY_LOCKED: begin
        if (bus.key_wr) begin
          key_d = (bus.key_data == KEY_FIRST) ? KEY_FIRST_SEEN : KEY_LOCKOUT;
        end else if (flash_wr) begin
          key_d = KEY_LOCKOUT;
        end
      end
      KEY_FIRST_SEEN: begin
        if (bus.key_wr) begin
          key_d = (bus.key_data == KEY_SECOND) ? KEY_ARMED : KEY_LOCKOUT;
        end else if (flash_wr) begin
          key_d = KEY_LOCKOUT;
        end
      end
      KEY_ARMED: begin
        if (flash_wr) begin
          key_d = KEY_LOCKED;
        end else if (bus.key_wr) begin
          key_d = KEY_LOCKOUT;
        end
      end
      KEY_LOCKOUT: begin
        key_d = KEY_LOCKOUT;
      end
      default: key_d = KEY_LOCKOUT;
    endcase
  end

  // Flags taken from the next state so outputs stay registered
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      key_q <= KEY_LOCKED;
      armed_q <= 1'b0;
      locked_out_q <= 1'b0;
    end else begin
      key_q <= key_d;
      armed_q <= (key_d == KEY_ARMED);
      locked_out_q <= (key_d == KEY_LOCKOUT);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      op_q <= OP_IDLE;
      timer_q <= '0;
      stall_q <= 1'b0;
      op_addr_q <= '0;
      op_data_q <= '0;
    end else begin
      case (op_q)
        OP_IDLE: begin
          if (start_op) begin
            op_q <= ee_q ? OP_ERASE : OP_PROGRAM;
            timer_q <= ee_q ? TIMER_W'(ERASE_CYCLES - 1) : TIMER_W'(WRITE_CYCLES - 1);
            stall_q <= 1'b1;
            op_addr_q <= bus.ext_addr[FLASH_IDX_W-1:0];
            op_data_q <= bus.ext_wdata;
          end
        end
        OP_PROGRAM, OP_ERASE: begin
          if (timer_q == '0) begin
            op_q <= OP_IDLE;
            stall_q <= 1'b0;
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        default: begin
          op_q <= OP_IDLE;
          stall_q <= 1'b0;
        end
      endcase
    end
  end

  // erase walks page one byte per cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      erase_idx_q <= '0;
    end else if (start_op) begin
      erase_idx_q <= {bus.ext_addr[FLASH_IDX_W-1:PAGE_OFF_W], {PAGE_OFF_W{1'b0}}};
    end else if (op_q == OP_ERASE && erase_idx_q[PAGE_OFF_W-1:0] != {PAGE_OFF_W{1'b1}}) begin
      erase_idx_q <= erase_idx_q + 1'b1;
    end
  end

  // Flash array has no reset: contents are non-volatile
  always_ff @(posedge mclk) begin
    if (op_q == OP_PROGRAM && timer_q == '0) begin
      flash_q[op_addr_q] <= flash_q[op_addr_q] & op_data_q;
    end else if (op_q == OP_ERASE) begin
      flash_q[erase_idx_q] <= ERASED_BYTE;
    end
  end

  // Data RAM receives writes while flash steering is off
  // Same depth as flash, so only low address bits matter
  always_ff @(posedge mclk) begin
    if (bus.ext_wr && !we_q && !stall_q) begin
      ram_q[bus.ext_addr[FLASH_IDX_W-1:0]] <= bus.ext_wdata;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      code_rdata_q <= '0;
      ram_rdata_q <= '0;
    end else begin
      if (bus.code_rd) begin
        code_rdata_q <= flash_q[bus.rd_addr[FLASH_IDX_W-1:0]];
      end
      if (bus.ext_rd) begin
        ram_rdata_q <= ram_q[bus.rd_addr[FLASH_IDX_W-1:0]];
      end
    end
  end

  // Every output is a register
  assign bus.code_rdata = code_rdata_q;
  assign bus.ram_rdata = ram_rdata_q;
  assign bus.stall = stall_q;
  assign bus.locked_out = locked_out_q;
  assign bus.armed = armed_q;
  assign bus.program_store_write_enable = we_q;
  assign bus.program_store_erase_enable = ee_q;
endmodule

// file: core/flash_core_requester.sv
`timescale 1ns/100ps
module flash_core_requester
  import flash_pe_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  flash_pe_if.core bus,
  input wire logic req_valid,
  input wire logic req_erase,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_data,
  output logic req_ready,
  output logic done
);
  typedef enum logic [2:0] {
    S_IDLE, S_CTL, S_KEY1, S_KEY2, S_WRITE, S_WAIT, S_CLEAR
  } seq_t;
  seq_t st_q;
  logic erase_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic done_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      erase_q <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (req_valid) begin
            erase_q <= req_erase;
            addr_q <= req_addr;
            data_q <= req_data;
            st_q <= S_CTL;
          end
        end
        S_CTL: st_q <= S_KEY1;
        S_KEY1: st_q <= S_KEY2;
        S_KEY2: st_q <= S_WRITE;
        S_WRITE: st_q <= S_WAIT;
        S_WAIT: begin
          if (!bus.stall) begin
            st_q <= S_CLEAR;
          end
        end
        S_CLEAR: begin
          st_q <= S_IDLE;
          done_q <= 1'b1;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  always_comb begin
    bus.key_wr = (st_q == S_KEY1) || (st_q == S_KEY2);
    bus.key_data = (st_q == S_KEY1) ? KEY_FIRST : KEY_SECOND;
    bus.ctl_wr = (st_q == S_CTL) || (st_q == S_CLEAR);
    bus.write_enable_in = (st_q == S_CTL);
    bus.erase_enable_in = (st_q == S_CTL) && erase_q;
    bus.timing_enable_in = 1'b1;
    bus.ext_wr = (st_q == S_WRITE);
    bus.ext_short = 1'b0;
    bus.ext_addr = addr_q;
    bus.ext_wdata = data_q;
    bus.ext_rd = 1'b0;
    bus.code_rd = 1'b0;
    bus.rd_addr = addr_q;
  end

  assign req_ready = (st_q == S_IDLE);
  assign done = done_q;
endmodule

// file: bench/flash_pe_properties.sv
`timescale 1ns/100ps
module flash_pe_properties
  import flash_pe_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic ext_wr,
  input wire logic stall,
  input wire logic armed,
  input wire logic locked_out,
  input wire logic program_store_write_enable,
  input wire logic program_store_erase_enable
);
  int scnt_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Stall length counter; too long for a repetition
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      scnt_q <= 0;
    else
      scnt_q <= stall ? scnt_q + 1 : 0;
  end
  sequence flash_wr_s;
    ext_wr && !stall && program_store_write_enable;
  endsequence
  sequence second_key_s;
    $past(key_wr) && $past(key_data) == KEY_SECOND;
  endsequence
  op_length_a: assert property ($fell(stall) |->
    scnt_q == (program_store_erase_enable ? ERASE_CYCLES : WRITE_CYCLES)) else $error("stall length wrong");
  stall_cause_a: assert property ($rose(stall) |->
    $past(ext_wr) || $past(ext_wr, 2)) else $error("stall without write");
  relock_a: assert property (flash_wr_s ##0 armed |=> !armed && !locked_out)
    else $error("no relock after write");
  early_wr_a: assert property (flash_wr_s ##0 !armed |=> locked_out && !stall ##1 !stall)
    else $error("early write not locked out");
  lockout_hold_a: assert property (locked_out |=> locked_out) else $error("lockout left");
  arm_cause_a: assert property ($rose(armed) |-> second_key_s) else $error("armed without key");
  key_armed_a: assert property (key_wr && armed |=> locked_out) else $error("key while armed");
  bad_key_a: assert property (key_wr && key_data != KEY_FIRST && key_data != KEY_SECOND |=>
    locked_out) else $error("wrong key accepted");
endmodule

// file: bench/tb_flash_program_erase_control.sv
`timescale 1ns/100ps
module tb_flash_program_erase_control;
  import flash_pe_pkg::*;
  logic mclk = 0;
  logic sys_rst = 1;
  logic req_valid = 0;
  logic req_erase = 0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_data = '0;
  logic req_ready;
  logic done;
  int n_errors = 0;
  int tests_run = 0;
  int n;
  flash_pe_if ifa();
  flash_pe_if ifb();
  flash_program_erase_control flash_program_erase_control_i (.mclk, .sys_rst, .bus(ifa.device));
  flash_core_requester flash_core_requester_i (.mclk, .sys_rst, .bus(ifa.core), .req_valid, .req_erase,
    .req_addr, .req_data, .req_ready, .done);
  // Second device, driven by hand so faults can be injected
  flash_program_erase_control flash_program_erase_control_f_i (.mclk, .sys_rst, .bus(ifb.device));
  // Checker watches the hand-driven device, which also sees the faults
  flash_pe_properties flash_pe_properties_i (.mclk, .sys_rst, .key_wr(ifb.key_wr), .key_data(ifb.key_data),
    .ext_wr(ifb.ext_wr), .stall(ifb.stall), .armed(ifb.armed), .locked_out(ifb.locked_out),
    .program_store_write_enable(ifb.program_store_write_enable),
    .program_store_erase_enable(ifb.program_store_erase_enable));
  always #20 mclk = ~mclk;
  task automatic print_verdict();
    $display("Errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ctl(input logic we, input logic ee);
    ifb.write_enable_in = we;
    ifb.erase_enable_in = ee;
    ifb.ctl_wr = 1;
    @(negedge mclk) ifb.ctl_wr = 0;
  endtask
  task automatic key(input logic [7:0] d);
    ifb.key_data = d;
    ifb.key_wr = 1;
    @(negedge mclk) ifb.key_wr = 0;
    @(negedge mclk);
  endtask
  task automatic unlock();
    key(KEY_FIRST);
    key(KEY_SECOND);
  endtask
  task automatic xw(input logic [15:0] a, input logic [7:0] d, input logic s);
    ifb.ext_addr = a;
    ifb.ext_wdata = d;
    ifb.ext_short = s;
    ifb.ext_wr = 1;
    @(negedge mclk) ifb.ext_wr = 0;
    n = 0;
    // Bound covers the longest erase
    for (int i = 0; i < 600 && ifb.stall === 1'b1; i++) begin
      n++;
      @(negedge mclk);
    end
  endtask
  task automatic rd(input logic c, input logic [15:0] a, input logic [7:0] exp);
    ifb.rd_addr = a;
    ifb.code_rd = c;
    ifb.ext_rd = !c;
    @(negedge mclk);
    ifb.code_rd = 0;
    ifb.ext_rd = 0;
    chk("rdata", c ? ifb.code_rdata : ifb.ram_rdata, 16'(exp));
    @(negedge mclk);
  endtask
  task automatic t_requester(input logic er, input logic [15:0] a, input logic [7:0] d);
    req_erase = er;
    req_addr = a;
    req_data = d;
    req_valid = 1;
    @(negedge mclk) req_valid = 0;
    for (int i = 0; i < 700 && done !== 1'b1; i++) @(negedge mclk);
    chk("done", 16'(done), 1);
    chk("req_ready", 16'(req_ready), 1);
    chk("we_cleared", 16'(ifa.program_store_write_enable), 0);
    chk("relocked", 16'(ifa.armed), 0);
    chk("no_lockout", 16'(ifa.locked_out), 0);
  endtask
  task automatic t_program();
    ctl(1, 1);
    unlock();
    xw(16'h0234, 8'h00, 0);
    chk("erase_stall", 16'(n), 16'(ERASE_CYCLES));
    rd(1, 16'h0200, ERASED_BYTE);
    rd(1, 16'h03FF, ERASED_BYTE);
    ctl(1, 0);
    unlock();
    xw(16'h0234, 8'h3C, 0);
    chk("write_stall", 16'(n), 16'(WRITE_CYCLES));
    rd(1, 16'h0234, 8'h3C);
    rd(1, 16'h0235, ERASED_BYTE);
    unlock();
    xw(16'h0234, 8'hF5, 0);
    rd(1, 16'h0234, 8'h34);
    chk("armed", 16'(ifb.armed), 0);
  endtask
  task automatic t_refused();
    unlock();
    xw(16'h0300, 8'h00, 1);
    chk("short_stall", 16'(n), 0);
    rd(1, 16'h0300, ERASED_BYTE);
    ifb.timing_enable_in = 0;
    unlock();
    xw(16'h0300, 8'h00, 0);
    ifb.timing_enable_in = 1;
    rd(1, 16'h0300, ERASED_BYTE);
    chk("locked_out", 16'(ifb.locked_out), 0);
  endtask
  task automatic t_ram();
    ctl(0, 0);
    xw(16'h0234, 8'h77, 0);
    ctl(1, 0);
    rd(0, 16'h0234, 8'h77);
    rd(1, 16'h0234, 8'h34);
  endtask
  task automatic t_early();
    xw(16'h0235, 8'h00, 0);
    chk("locked_out", 16'(ifb.locked_out), 1);
    unlock();
    xw(16'h0235, 8'h00, 0);
    chk("lockout_stall", 16'(n), 0);
    rd(1, 16'h0235, ERASED_BYTE);
  endtask
  task automatic t_keys(input logic [7:0] k1, input logic [7:0] k2, input logic lo);
    sys_rst = 1;
    @(negedge mclk) sys_rst = 0;
    key(k1);
    key(k2);
    chk("locked_out", 16'(ifb.locked_out), 16'(lo));
    chk("armed", 16'(ifb.armed), 16'(!lo));
  endtask
  initial begin
    ifb.key_wr = 0;
    ifb.key_data = '0;
    ifb.ctl_wr = 0;
    ifb.write_enable_in = 0;
    ifb.erase_enable_in = 0;
    ifb.timing_enable_in = 1;
    ifb.ext_wr = 0;
    ifb.ext_short = 0;
    ifb.ext_addr = '0;
    ifb.ext_wdata = '0;
    ifb.ext_rd = 0;
    ifb.code_rd = 0;
    ifb.rd_addr = '0;
    repeat (8) @(negedge mclk);
    sys_rst = 0;
    t_requester(1, 16'h0200, 8'h00);
    t_requester(0, 16'h0210, 8'h5A);
    t_program();
    t_refused();
    t_ram();
    t_early();
    t_keys(KEY_FIRST, 8'h12, 1);
    t_keys(KEY_SECOND, KEY_FIRST, 1);
    t_keys(KEY_FIRST, KEY_SECOND, 0);
    key(KEY_FIRST);
    chk("locked_out", 16'(ifb.locked_out), 1);
    print_verdict();
  end
  // Run needs about 1150 cycles; nearly nine times that is a hang
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
endmodule
